/* atrig_pkg.sv */
package atrig_pkg;
    localparam int SAMPLE_W = 16;
    localparam int DAC_W    = 16;
    localparam int CHAN_W   = 7;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_LEVEL  = 8'h04;
    localparam logic [7:0] OFS_HYST   = 8'h08;
    localparam logic [7:0] OFS_TOP    = 8'h0c;
    localparam logic [7:0] OFS_BOTTOM = 8'h10;
    localparam logic [7:0] OFS_ROUTE  = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_DAC    = 8'h1c;

    // control fields
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_SRC_BIT    = 4;
    localparam int CTRL_TERM_BIT   = 5;
    localparam int CTRL_LEAVE_BIT  = 6;
    localparam int CTRL_CHAN_LSB   = 8;
    localparam int CTRL_GAIN_LSB   = 16;
    localparam int CTRL_ACTION_LSB = 20;

    // route fields
    localparam int ROUTE_PFT_EN_BIT = 0;
    localparam int ROUTE_PFT_LSB    = 1;
    localparam int ROUTE_SYNC_EN_BIT = 8;
    localparam int ROUTE_SYNC_LSB   = 9;

    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
    localparam logic [15:0] LEVEL_RESET = 16'h0000;

    typedef enum logic [2:0] {
        MODE_BELOW   = 3'h0,
        MODE_ABOVE   = 3'h1,
        MODE_HYST_RISE = 3'h2,
        MODE_HYST_FALL = 3'h3,
        MODE_WINDOW  = 3'h4
    } trig_mode_t;

    // gain: left shift amount applied to channel samples
    function automatic logic signed [SAMPLE_W-1:0] scale_sample(
        input logic signed [SAMPLE_W-1:0] s,
        input logic [1:0]                 g);
        logic signed [SAMPLE_W+2:0] w;
        w = {{3{s[SAMPLE_W-1]}}, s} <<< g;
        if (w > $signed({4'h0, {(SAMPLE_W-1){1'b1}}}))
            scale_sample = {1'b0, {(SAMPLE_W-1){1'b1}}};
        else if (w < $signed({4'hf, {(SAMPLE_W-1){1'b0}}}))
            scale_sample = {1'b1, {(SAMPLE_W-1){1'b0}}};
        else
            scale_sample = w[SAMPLE_W-1:0];
    endfunction
endpackage

/* atrig_cfg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface atrig_cfg_if;
    logic                                clear;
    logic [2:0]                          mode;
    logic                                leave;
    logic signed [atrig_pkg::DAC_W-1:0]  thr_hi;
    logic signed [atrig_pkg::DAC_W-1:0]  thr_lo;
    logic signed [atrig_pkg::SAMPLE_W-1:0] sample;
    logic                                event_out;

    modport ctrl (
        output clear,
        output mode,
        output leave,
        output thr_hi,
        output thr_lo,
        output sample,
        input  event_out
    );
    modport det (
        input  clear,
        input  mode,
        input  leave,
        input  thr_hi,
        input  thr_lo,
        input  sample,
        output event_out
    );
endinterface
`default_nettype wire

/* atrig_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module atrig_sync (
    input  wire logic                              clk_sys,
    input  wire logic                              rstn,
    input  wire logic signed [atrig_pkg::SAMPLE_W-1:0] d,
    output logic signed [atrig_pkg::SAMPLE_W-1:0]  q
);
    logic signed [atrig_pkg::SAMPLE_W-1:0] meta_reg;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* atrig_detect.sv */
`timescale 1ns/10ps
`default_nettype none
module atrig_detect (
    input  wire logic clk_sys,
    input  wire logic rstn,
    atrig_cfg_if.det  cfg
);
    logic armed_reg;
    logic event_reg;
    logic prev_in_reg;
    logic prev_valid_reg;
    logic in_win;

    assign in_win = (cfg.sample < cfg.thr_hi) && (cfg.sample > cfg.thr_lo);
    assign cfg.event_out = event_reg;

    always_ff @(posedge clk_sys) begin
        if (!rstn || cfg.clear) begin
            armed_reg      <= 1'b0; // [RULE17]
            event_reg      <= 1'b0; // [RULE17]
            prev_in_reg    <= 1'b0;
            prev_valid_reg <= 1'b0;
        end else begin
            prev_in_reg    <= in_win;
            prev_valid_reg <= 1'b1;
            unique case (cfg.mode)
                3'h0: event_reg <= cfg.sample < cfg.thr_lo; // [RULE8]
                3'h1: event_reg <= cfg.sample > cfg.thr_hi; // [RULE9]
                3'h2: begin
                    if (cfg.sample < cfg.thr_lo) begin
                        armed_reg <= 1'b1;
                        event_reg <= 1'b0; // [RULE11]
                    end else if (armed_reg && cfg.sample > cfg.thr_hi) begin
                        event_reg <= 1'b1; // [RULE11]
                    end
                end
                3'h3: begin
                    if (cfg.sample > cfg.thr_hi) begin
                        armed_reg <= 1'b1;
                        event_reg <= 1'b0; // [RULE13]
                    end else if (armed_reg && cfg.sample < cfg.thr_lo) begin
                        event_reg <= 1'b1; // [RULE13]
                    end
                end
                3'h4: begin
                    if (prev_valid_reg && (prev_in_reg != in_win))
                        event_reg <= cfg.leave ? !in_win : in_win; // [RULE14]
                end
                default: event_reg <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* atrig_top.sv */
// Functional notes
// [RULE1] source is trigger terminal or any channel
// [RULE2] muxed start trigger channel listed first
// [RULE3] muxed reference/pause trigger: one channel only
// [RULE4] hold trigger channel on amplifier while waiting
// [RULE5] per-channel amplifiers: trigger channel in scan list
// [RULE6] one event, selectable by each subsystem
// [RULE7] event routable to function terminals, sync lines
// [RULE8] below mode: event while source under level
// [RULE9] above mode: event while source over level
// [RULE10] rising hysteresis: high=level, low=level minus hysteresis
// [RULE11] rising: arm below low, assert above high
// [RULE12] falling hysteresis: low=level, high=level plus hysteresis
// [RULE13] falling: arm above high, assert below low
// [RULE14] window: trigger on entering, or leaving
// [RULE15] compare against converters, writes update them
// [RULE16] channels amplified by range, terminals not
// [RULE17] trackers start deasserted and unarmed
`timescale 1ns/10ps
`default_nettype none
module atrig_top (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rstn,
    input  wire logic [31:0]                           haddr,
    input  wire logic [1:0]                            htrans,
    input  wire logic                                  hwrite,
    input  wire logic [2:0]                            hsize,
    input  wire logic [31:0]                           hwdata,
    input  wire logic                                  hsel,
    input  wire logic                                  hready,
    output logic [31:0]                                hrdata,
    output logic                                       hreadyout,
    output logic                                       hresp,
    input  wire logic signed [atrig_pkg::SAMPLE_W-1:0] analog_trigger_input_terminal0,
    input  wire logic signed [atrig_pkg::SAMPLE_W-1:0] analog_trigger_input_terminal1,
    input  wire logic signed [atrig_pkg::SAMPLE_W-1:0] amp_sample,
    input  wire logic                                  acq_waiting,
    output logic [atrig_pkg::CHAN_W-1:0]               mux_chan,
    output logic                                       mux_hold,
    output logic [1:0]                                 amp_gain,
    output logic [atrig_pkg::DAC_W-1:0]                dac_hi,
    output logic [atrig_pkg::DAC_W-1:0]                dac_lo,
    output logic                                       trig_ai,
    output logic                                       trig_ao,
    output logic                                       trig_di,
    output logic                                       trig_do,
    output logic                                       trig_ctr,
    output logic [15:0]                                programmable_function_terminal,
    output logic [15:0]                                programmable_function_terminal_oe,
    output logic [7:0]                                 sync_bus_line,
    output logic [7:0]                                 sync_bus_line_oe
);
    logic [31:0]                           ctrl_reg;
    logic [31:0]                           route_reg;
    logic signed [atrig_pkg::DAC_W-1:0]    level_reg;
    logic signed [atrig_pkg::DAC_W-1:0]    hyst_reg;
    logic signed [atrig_pkg::DAC_W-1:0]    top_reg;
    logic signed [atrig_pkg::DAC_W-1:0]    bottom_reg;
    logic signed [atrig_pkg::DAC_W-1:0]    thr_hi_reg;
    logic signed [atrig_pkg::DAC_W-1:0]    thr_lo_reg;
    logic                                  cfg_dirty_reg;
    logic                                  dph_valid_reg;
    logic                                  dph_write_reg;
    logic [7:0]                            dph_addr_reg;
    logic signed [atrig_pkg::SAMPLE_W-1:0] term0_s;
    logic signed [atrig_pkg::SAMPLE_W-1:0] term1_s;
    logic signed [atrig_pkg::SAMPLE_W-1:0] amp_s;
    logic signed [atrig_pkg::SAMPLE_W-1:0] src_next;
    logic signed [atrig_pkg::SAMPLE_W-1:0] src_reg;
    logic [2:0]                            mode;
    logic                                  enable;
    logic                                  evt;
    logic                                  evt_gated;
    logic [4:0]                            action;
    logic                                  addr_phase;

    atrig_cfg_if cfg_bus ();

    atrig_sync u_sync_t0 (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       (analog_trigger_input_terminal0),
        .q       (term0_s)
    );
    atrig_sync u_sync_t1 (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       (analog_trigger_input_terminal1),
        .q       (term1_s)
    );
    atrig_sync u_sync_amp (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       (amp_sample),
        .q       (amp_s)
    );

    assign enable = ctrl_reg[atrig_pkg::CTRL_EN_BIT];
    assign mode   = ctrl_reg[atrig_pkg::CTRL_MODE_LSB +: 3];
    assign action = ctrl_reg[atrig_pkg::CTRL_ACTION_LSB +: 5];

    // bus slave, zero wait states
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dph_valid_reg <= 1'b0;
            dph_write_reg <= 1'b0;
            dph_addr_reg  <= 8'h00;
        end else begin
            dph_valid_reg <= addr_phase;
            dph_write_reg <= hwrite;
            dph_addr_reg  <= haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_reg      <= atrig_pkg::CTRL_RESET;
            route_reg     <= atrig_pkg::ROUTE_RESET;
            level_reg     <= atrig_pkg::LEVEL_RESET;
            hyst_reg      <= atrig_pkg::LEVEL_RESET;
            top_reg       <= atrig_pkg::LEVEL_RESET;
            bottom_reg    <= atrig_pkg::LEVEL_RESET;
            cfg_dirty_reg <= 1'b0;
        end else begin
            cfg_dirty_reg <= 1'b0;
            if (dph_valid_reg && dph_write_reg) begin
                cfg_dirty_reg <= 1'b1;
                unique case (dph_addr_reg)
                    atrig_pkg::OFS_CTRL:   ctrl_reg   <= hwdata;
                    atrig_pkg::OFS_LEVEL:  level_reg  <= hwdata[atrig_pkg::DAC_W-1:0];
                    atrig_pkg::OFS_HYST:   hyst_reg   <= hwdata[atrig_pkg::DAC_W-1:0];
                    atrig_pkg::OFS_TOP:    top_reg    <= hwdata[atrig_pkg::DAC_W-1:0];
                    atrig_pkg::OFS_BOTTOM: bottom_reg <= hwdata[atrig_pkg::DAC_W-1:0];
                    atrig_pkg::OFS_ROUTE:  route_reg  <= hwdata;
                    default:               cfg_dirty_reg <= 1'b0;
                endcase
            end
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (dph_valid_reg && !dph_write_reg) begin
            unique case (dph_addr_reg)
                atrig_pkg::OFS_CTRL:   hrdata = ctrl_reg;
                atrig_pkg::OFS_LEVEL:  hrdata = {16'h0000, level_reg};
                atrig_pkg::OFS_HYST:   hrdata = {16'h0000, hyst_reg};
                atrig_pkg::OFS_TOP:    hrdata = {16'h0000, top_reg};
                atrig_pkg::OFS_BOTTOM: hrdata = {16'h0000, bottom_reg};
                atrig_pkg::OFS_ROUTE:  hrdata = route_reg;
                atrig_pkg::OFS_STATUS: hrdata = {24'h00_0000, 5'h00, mux_hold, src_reg[atrig_pkg::SAMPLE_W-1], evt};
                atrig_pkg::OFS_DAC:    hrdata = {thr_hi_reg, thr_lo_reg};
                default:               hrdata = 32'h0000_0000;
            endcase
        end
    end

    // threshold converter settings follow the programmed values
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            thr_hi_reg <= '0;
            thr_lo_reg <= '0;
        end else begin
            unique case (mode)
                atrig_pkg::MODE_HYST_RISE: begin
                    thr_hi_reg <= level_reg; // [RULE10] [RULE15]
                    thr_lo_reg <= level_reg - hyst_reg; // [RULE10]
                end
                atrig_pkg::MODE_HYST_FALL: begin
                    thr_lo_reg <= level_reg; // [RULE12] [RULE15]
                    thr_hi_reg <= level_reg + hyst_reg; // [RULE12]
                end
                atrig_pkg::MODE_WINDOW: begin
                    thr_hi_reg <= top_reg; // [RULE15]
                    thr_lo_reg <= bottom_reg;
                end
                default: begin
                    thr_hi_reg <= level_reg; // [RULE15]
                    thr_lo_reg <= level_reg;
                end
            endcase
        end
    end
    assign dac_hi = thr_hi_reg;
    assign dac_lo = thr_lo_reg;

    // source selection
    always_comb begin
        if (ctrl_reg[atrig_pkg::CTRL_SRC_BIT])
            src_next = atrig_pkg::scale_sample(amp_s, ctrl_reg[atrig_pkg::CTRL_GAIN_LSB +: 2]); // [RULE16]
        else if (ctrl_reg[atrig_pkg::CTRL_TERM_BIT])
            src_next = term1_s; // [RULE1] [RULE16]
        else
            src_next = term0_s; // [RULE1]
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn)
            src_reg <= '0;
        else
            src_reg <= src_next;
    end

    // keep the trigger channel on the amplifier while waiting
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mux_hold <= 1'b0;
            mux_chan <= '0;
            amp_gain <= 2'h0;
        end else begin
            mux_hold <= enable && ctrl_reg[atrig_pkg::CTRL_SRC_BIT] && acq_waiting; // [RULE4]
            mux_chan <= ctrl_reg[atrig_pkg::CTRL_CHAN_LSB +: atrig_pkg::CHAN_W]; // [RULE1]
            amp_gain <= ctrl_reg[atrig_pkg::CTRL_GAIN_LSB +: 2]; // [RULE16]
        end
    end

    assign cfg_bus.clear  = !enable || cfg_dirty_reg; // [RULE17]
    assign cfg_bus.mode   = mode;
    assign cfg_bus.leave  = ctrl_reg[atrig_pkg::CTRL_LEAVE_BIT];
    assign cfg_bus.thr_hi = thr_hi_reg;
    assign cfg_bus.thr_lo = thr_lo_reg;
    assign cfg_bus.sample = src_reg;
    assign evt            = cfg_bus.event_out;

    atrig_detect u_detect (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cfg     (cfg_bus)
    );

    assign evt_gated = evt && enable;

    // event fan-out and routing
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            trig_ai  <= 1'b0;
            trig_ao  <= 1'b0;
            trig_di  <= 1'b0;
            trig_do  <= 1'b0;
            trig_ctr <= 1'b0;
            programmable_function_terminal    <= 16'h0000;
            programmable_function_terminal_oe <= 16'h0000;
            sync_bus_line    <= 8'h00;
            sync_bus_line_oe <= 8'h00;
        end else begin
            trig_ai  <= evt_gated && action[0]; // [RULE6]
            trig_ao  <= evt_gated && action[1]; // [RULE6]
            trig_di  <= evt_gated && action[2]; // [RULE6]
            trig_do  <= evt_gated && action[3]; // [RULE6]
            trig_ctr <= evt_gated && action[4]; // [RULE6]
            programmable_function_terminal    <= 16'h0000;
            programmable_function_terminal_oe <= 16'h0000;
            sync_bus_line    <= 8'h00;
            sync_bus_line_oe <= 8'h00;
            if (route_reg[atrig_pkg::ROUTE_PFT_EN_BIT]) begin
                programmable_function_terminal[route_reg[atrig_pkg::ROUTE_PFT_LSB +: 4]]    <= evt_gated; // [RULE7]
                programmable_function_terminal_oe[route_reg[atrig_pkg::ROUTE_PFT_LSB +: 4]] <= 1'b1;
            end
            if (route_reg[atrig_pkg::ROUTE_SYNC_EN_BIT]) begin
                sync_bus_line[route_reg[atrig_pkg::ROUTE_SYNC_LSB +: 3]]    <= evt_gated; // [RULE7]
                sync_bus_line_oe[route_reg[atrig_pkg::ROUTE_SYNC_LSB +: 3]] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* atrig_top_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module atrig_top_monitor (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        acq_waiting,
    input wire logic        mux_hold,
    input wire logic [6:0]  mux_chan,
    input wire logic [1:0]  amp_gain,
    input wire logic [15:0] dac_hi,
    input wire logic [15:0] dac_lo,
    input wire logic        trig_ai,
    input wire logic [15:0] programmable_function_terminal,
    input wire logic [15:0] programmable_function_terminal_oe,
    input wire logic [7:0]  sync_bus_line,
    input wire logic [7:0]  sync_bus_line_oe
);
    logic rd_reg;
    logic wr_reg;
    always_ff @(posedge clk_sys) begin
        rd_reg <= rstn && hsel && hready && htrans[1] && !hwrite;
        wr_reg <= rstn && hsel && hready && htrans[1] && hwrite;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus not okay");
    chk_read_idle: assert property (!rd_reg |-> hrdata == 32'h0)
        else $error("stray read data");
    chk_pft_single: assert property ($onehot0(programmable_function_terminal_oe))
        else $error("two terminals driven");
    chk_sync_single: assert property ($onehot0(sync_bus_line_oe))
        else $error("two sync lines driven");
    chk_pft_gated: assert property ((programmable_function_terminal & ~programmable_function_terminal_oe) == 16'h0)
        else $error("terminal not driven");
    chk_sync_gated: assert property ((sync_bus_line & ~sync_bus_line_oe) == 8'h0)
        else $error("sync line not driven");
    chk_hold_wait: assert property (!acq_waiting [*2] |=> !mux_hold)
        else $error("mux held idle");
    chk_dac_write: assert property ($changed(dac_hi) || $changed(dac_lo) |-> $past(wr_reg) || $past(wr_reg, 2))
        else $error("dac moved alone");
    chk_cfg_write: assert property ($changed(mux_chan) || $changed(amp_gain) |-> $past(wr_reg) || $past(wr_reg, 2))
        else $error("mux moved alone");
    cov_event: cover property ($rose(trig_ai));
    cov_hold: cover property ($rose(mux_hold));
    cov_route: cover property (programmable_function_terminal != 16'h0);
endmodule
bind atrig_top atrig_top_monitor atrig_top_monitor_inst (.*);
`default_nettype wire

/* atrig_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module atrig_src_model (
    input wire logic               clk_sys,
    input wire logic               slow,
    input wire logic signed [15:0] v0,
    input wire logic signed [15:0] v1,
    input wire logic signed [15:0] vc,
    output logic signed [15:0]     term0,
    output logic signed [15:0]     term1,
    output logic signed [15:0]     amp
);
    // slow mode slews 16 counts per cycle
    function automatic logic signed [15:0] step(input logic signed [15:0] c, input logic signed [15:0] t);
        if (c < t - 16'sd16)
            step = c + 16'sd16;
        else if (c > t + 16'sd16)
            step = c - 16'sd16;
        else
            step = t;
    endfunction
    // always driven
    always_ff @(posedge clk_sys) begin
        term0 <= slow ? step(term0, v0) : v0;
        term1 <= slow ? step(term1, v1) : v1;
        amp   <= slow ? step(amp, vc) : vc;
    end
endmodule
`default_nettype wire

/* test_atrig_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_atrig_top;
    logic               clk_sys = 1'b0;
    logic               rstn = 1'b0, hwrite = 1'b0, hsel = 1'b0, acq = 1'b0, slow = 1'b0;
    logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0]         htrans = 2'h0, amp_gain;
    logic               hreadyout, hresp, mux_hold, t_ai, t_ao, t_di, t_do, t_ctr;
    logic signed [15:0] v0 = 16'sh0, v1 = 16'sh0, vc = 16'sh0, a0, a1, ac;
    logic [6:0]         mux_chan;
    logic [15:0]        dac_hi, dac_lo, pft, pft_oe;
    logic [7:0]         sbl, sbl_oe;
    int                 fail_count = 0, checks_done = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    atrig_top atrig_top_inst (.clk_sys(clk_sys), .rstn(rstn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .analog_trigger_input_terminal0(a0), .analog_trigger_input_terminal1(a1),
        .amp_sample(ac), .acq_waiting(acq), .mux_chan(mux_chan), .mux_hold(mux_hold), .amp_gain(amp_gain),
        .dac_hi(dac_hi), .dac_lo(dac_lo), .trig_ai(t_ai), .trig_ao(t_ao), .trig_di(t_di), .trig_do(t_do),
        .trig_ctr(t_ctr), .programmable_function_terminal(pft), .programmable_function_terminal_oe(pft_oe),
        .sync_bus_line(sbl), .sync_bus_line_oe(sbl_oe));
    atrig_src_model atrig_src_model_inst (.clk_sys(clk_sys), .slow(slow), .v0(v0), .v1(v1), .vc(vc),
        .term0(a0), .term1(a1), .amp(ac));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        int n = 0;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= 2'h2;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, rdv);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0, rdv);
        cmp(rdv, exp);
    endtask
    task automatic settle(input logic signed [15:0] a, input logic signed [15:0] b, input logic signed [15:0] c);
        v0 <= a;
        v1 <= b;
        vc <= c;
        repeat (20) @(posedge clk_sys);
    endtask
    task automatic ev(input logic e);
        cmp({27'h0, t_ai, t_ao, t_di, t_do, t_ctr}, {27'h0, {5{e}}});
    endtask
    // fl: channel, terminal one, leaving
    function automatic logic [31:0] cf(input logic [2:0] m, input logic [2:0] fl = 3'h0, input logic [6:0] ch = 7'h0,
                                       input logic [1:0] g = 2'h0);
        cf = 32'h01f0_0001 | {28'h0, m, 1'b0} | {25'h0, fl, 4'h0} | {17'h0, ch, 8'h0} | {14'h0, g, 16'h0};
    endfunction
    task automatic t_reset;
        ev(1'b0);
        rd(atrig_pkg::OFS_CTRL, atrig_pkg::CTRL_RESET);
        rd(atrig_pkg::OFS_ROUTE, atrig_pkg::ROUTE_RESET);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0);
        wr(atrig_pkg::OFS_LEVEL, 32'h0000_ffff);
        rd(atrig_pkg::OFS_LEVEL, 32'h0000_ffff);
        $display("reset done");
    endtask
    task automatic t_level;
        wr(atrig_pkg::OFS_LEVEL, 32'd100);
        wr(atrig_pkg::OFS_CTRL, cf(3'h0));
        cmp({16'h0, dac_hi}, 32'd100);
        settle(50, 0, 0);
        ev(1'b1);
        settle(100, 0, 0);
        ev(1'b0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h1));
        settle(150, 0, 0);
        ev(1'b1);
        settle(100, 0, 0);
        ev(1'b0);
        settle(150, 0, 0);
        for (int k = 0; k < 5; k++) begin
            wr(atrig_pkg::OFS_CTRL, (cf(3'h1) & 32'h000f_ffff) | (32'h0100_0000 >> k));
            settle(150, 0, 0);
            cmp({27'h0, t_ai, t_ao, t_di, t_do, t_ctr}, 32'h1 << k);
        end
        $display("level done");
    endtask
    task automatic t_hyst_rise;
        slow <= 1'b1;
        wr(atrig_pkg::OFS_HYST, 32'd50);
        settle(75, 0, 0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h2));
        cmp({dac_hi, dac_lo}, {16'd100, 16'd50});
        settle(200, 0, 0);
        ev(1'b0);
        settle(20, 0, 0);
        ev(1'b0);
        settle(200, 0, 0);
        ev(1'b1);
        settle(75, 0, 0);
        ev(1'b1);
        settle(20, 0, 0);
        ev(1'b0);
        slow <= 1'b0;
        $display("rising done");
    endtask
    task automatic t_hyst_fall;
        settle(120, 0, 0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h3));
        cmp({dac_hi, dac_lo}, {16'd150, 16'd100});
        settle(50, 0, 0);
        ev(1'b0);
        settle(200, 0, 0);
        ev(1'b0);
        settle(50, 0, 0);
        ev(1'b1);
        settle(120, 0, 0);
        ev(1'b1);
        settle(200, 0, 0);
        ev(1'b0);
        $display("falling done");
    endtask
    task automatic t_window;
        wr(atrig_pkg::OFS_TOP, 32'd100);
        wr(atrig_pkg::OFS_BOTTOM, 32'h0000_ff9c);
        settle(500, 0, 0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h4));
        cmp({dac_hi, dac_lo}, 32'h0064_ff9c);
        ev(1'b0);
        settle(0, 0, 0);
        ev(1'b1);
        settle(500, 0, 0);
        ev(1'b0);
        settle(0, 0, 0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h4, 3'h4));
        settle(0, 0, 0);
        ev(1'b0);
        settle(-500, 0, 0);
        ev(1'b1);
        $display("window done");
    endtask
    task automatic t_route;
        wr(atrig_pkg::OFS_CTRL, cf(3'h1));
        settle(500, 0, 0);
        for (int i = 0; i < 16; i++) begin
            wr(atrig_pkg::OFS_ROUTE, 32'h1 | (i << 1));
            repeat (4) @(posedge clk_sys);
            cmp({pft, pft_oe}, {2{16'h1 << i}});
        end
        for (int j = 0; j < 8; j++) begin
            wr(atrig_pkg::OFS_ROUTE, 32'h100 | (j << 9));
            repeat (4) @(posedge clk_sys);
            cmp({pft_oe, sbl, sbl_oe}, {16'h0, {2{8'h1 << j}}});
        end
        $display("route done");
    endtask
    task automatic t_channel;
        acq <= 1'b1;
        wr(atrig_pkg::OFS_LEVEL, 32'd100);
        wr(atrig_pkg::OFS_CTRL, cf(3'h1, 3'h1, 7'h5, 2'h1));
        settle(0, 0, 60);
        ev(1'b1);
        cmp({22'h0, mux_hold, mux_chan, amp_gain}, {22'h0, 1'b1, 7'h5, 2'h1});
        acq <= 1'b0;
        settle(0, 0, 60);
        cmp({31'h0, mux_hold}, 32'h0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h1, 3'h1, 7'h5, 2'h0));
        settle(0, 0, 60);
        ev(1'b0);
        wr(atrig_pkg::OFS_CTRL, cf(3'h1, 3'h2, 7'h5, 2'h1));
        settle(500, 60, 500);
        ev(1'b0);
        settle(0, 150, 0);
        ev(1'b1);
        $display("channel done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_level;
        t_hyst_rise;
        t_hyst_fall;
        t_window;
        t_route;
        t_channel;
        print_verdict;
    end
endmodule
`default_nettype wire
